// *** hw/lism_pkg.sv ***
/*
 * lism_pkg: constants, field positions and carriers for the link
 * interrupt status and mask block.
 * Assumes an 8-bit byte address on a 32-bit AXI4-Lite register bus.
 */
package lism_pkg;

    // register byte addresses
    localparam logic [7:0] LISM_FLAGS_ADDR = 8'h0c;
    localparam logic [7:0] LISM_MASK_ADDR  = 8'h10;
    localparam logic [7:0] LISM_TEST_ADDR  = 8'h80;

    // values after reset
    localparam logic [31:0] LISM_FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] LISM_MASK_RST  = 32'h0000_0000;
    localparam logic [1:0]  LISM_TEST_RST  = 2'h0;

    // bits that hold a flag, and those cleared by write-one
    localparam logic [31:0] LISM_FLAG_USED = 32'h7fcb_8fc8;
    localparam logic [31:0] LISM_FLAG_W1C  = 32'h7fcb_8fc0;

    // field positions in the event flag register
    localparam int LISM_B_SUM     = 31;
    localparam int LISM_B_ALERT   = 30;
    localparam int LISM_B_PHYREG  = 29;
    localparam int LISM_B_BUS_RST = 28;
    localparam int LISM_B_GAP     = 27;
    localparam int LISM_B_TXFREE  = 26;
    localparam int LISM_B_RXGOOD  = 25;
    localparam int LISM_B_CSRRST  = 24;
    localparam int LISM_B_SELFID  = 23;
    localparam int LISM_B_ACKRX   = 22;
    localparam int LISM_B_ISOQ    = 20;
    localparam int LISM_B_ASYNCQ  = 19;
    localparam int LISM_B_BUSY    = 17;
    localparam int LISM_B_HDRCRC  = 16;
    localparam int LISM_B_TCODE   = 15;
    localparam int LISM_B_SEC     = 11;
    localparam int LISM_B_CYCLE_START_SEEN   = 10;
    localparam int LISM_B_CYCDONE = 9;
    localparam int LISM_B_CYCPEND = 8;
    localparam int LISM_B_CYCMISS = 7;
    localparam int LISM_B_ARBLOST = 6;
    localparam int LISM_B_PIPE    = 3;

    // test control register fields
    localparam int LISM_T_OVR  = 0;
    localparam int LISM_T_PIPE = 1;

    // wraps without a cycle start before the loss flag
    localparam logic [1:0] LISM_MISS_WRAPS = 2'h2;

    localparam logic [1:0] LISM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LISM_RESP_SLVERR = 2'h2;

    // one-cycle event pulses from link, phy interface and cycle timer
    typedef struct packed {
        logic phys_layer_alert;
        logic phys_register_data_arrived;
        logic bus_reset_seen;
        logic fair_gap_seen;
        logic packet_sent;
        logic ack_settled;
        logic good_packet_received;
        logic csr_reset_write_seen;
        logic self_identify_done;
        logic acknowledge_received;
        logic async_queue_fault;
        logic busy_reply_sent;
        logic header_crc_fault;
        logic transaction_code_fault;
        logic cycle_start_seen;
        logic cycle_start_received;
        logic cycle_finished;
        logic cycle_offset_zero;
        logic cycle_wrap;
        logic cycle_start_arbitration_lost;
        logic pipe_fault;
    } lism_evt_s;

    // expand byte strobes into a bit mask
    function automatic logic [31:0] lism_strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

endpackage

// *** hw/lism_axil.sv ***
/*
 * lism_axil: AXI4-Lite slave front end, one write and one read in flight.
 * Assumes the parent decodes addresses and returns read data in the
 * same cycle the read address is offered.
 */
`timescale 1ns/1ps
`default_nettype none
module lism_axil (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic        wr_en,
    output var  logic [7:0]  wr_addr,
    output var  logic [31:0] wr_data,
    output var  logic [3:0]  wr_strb,
    input  wire logic        wr_ok,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    import lism_pkg::*;

    // both halves held and no response pending
    assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // write address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= LISM_RESP_OKAY;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? LISM_RESP_OKAY : LISM_RESP_SLVERR;
            end
            // ready again only after the response is gone
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= LISM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_ok ? LISM_RESP_OKAY : LISM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** hw/lism_cyc_watch.sv ***
/*
 * lism_cyc_watch: seconds tick and lost cycle start detection.
 * Assumes the seconds count and wrap pulse come from the cycle timer.
 */
`timescale 1ns/1ps
`default_nettype none
module lism_cyc_watch (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [6:0] cycle_seconds,
    input  wire logic       cycle_wrap,
    input  wire logic       cycle_start_received,
    input  wire logic       is_cycle_master,
    output var  logic       seconds_tick,
    output var  logic       cycle_start_missing
);
    import lism_pkg::*;

    logic [6:0] sec_q;
    logic       primed_q;
    logic [1:0] wraps_q;
    logic [1:0] wraps_d;

    // first sample after reset only primes, no spurious tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_q        <= 7'h00;
            primed_q     <= 1'b0;
            seconds_tick <= 1'b0;
        end else begin
            sec_q        <= cycle_seconds;
            primed_q     <= 1'b1;
            seconds_tick <= primed_q && (cycle_seconds == sec_q + 7'h01);
        end
    end

    // a cycle start restarts the count; a master never loses its own
    always_comb begin
        wraps_d = wraps_q;
        if (is_cycle_master || cycle_start_received) begin
            wraps_d = 2'h0;
        end else if (cycle_wrap) begin
            wraps_d = wraps_q + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wraps_q             <= 2'h0;
            cycle_start_missing <= 1'b0;
        end else begin
            cycle_start_missing <= (wraps_d == LISM_MISS_WRAPS);
            wraps_q <= (wraps_d == LISM_MISS_WRAPS) ? 2'h0 : wraps_d;
        end
    end

    AST_MASTER_NO_MISS : assert property (@(posedge aclk)
        disable iff (!aresetn)
        is_cycle_master |=> !cycle_start_missing)
        else $error("loss flagged while cycle master");
endmodule
`default_nettype wire

// *** hw/lism_top.sv ***
/*
 * lism_top: event flag register, enable mask and active-low interrupt
 * output of the link controller, with an AXI4-Lite register port.
 * Assumes event inputs are one-cycle pulses synchronous to aclk.
 */
// Contract
// - flags at 0Ch; write-one clears bits except summary and pipe fault
// - with override set, every flag bit is plainly readable and writable
// - mask at 10h is read/write; a one enables the matching flag
// - flags and mask reset to all zeros
// - bit 31 is the OR of enabled flags and drives the interrupt
// - interrupt pin active only while mask bit 31 is one
// - bit 30 set on a physical-layer interrupt
// - bit 29 set when phy register read data arrives
// - bit 28 set on bus reset, bit 27 on fair gap
// - bit 26 low on packet sent, high when ack settled; bit 22 on ack
// - bit 25 set on any correct packet, stored or not
// - bit 24 set on a packet to the reset-start register
// - bit 23 set when self-identification completes
// - bit 19 set on async queue fault; bit 20 always zero
// - bit 17 set when a busy ack is sent for a full queue
// - bit 16 set on header crc error for this node
// - bit 15 set on invalid transaction code in transmit queue
// - bit 11 set each time the seconds count increments
// - bit 10 on cycle start sent or seen; bit 9 on fair gap after
// - bit 8 set at cycle offset zero, held until cycle completes
// - bit 7 set when non-master sees two wraps without cycle start
// - bit 6 set when cycle start arbitration is lost
// - pipe fault cleared only by pipe reset then writing one to it; an override write of zero also clears it
`timescale 1ns/1ps
`default_nettype none
module lism_top (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    output var  logic [31:0]      s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire lism_pkg::lism_evt_s evt,
    input  wire logic [6:0]       cycle_seconds,
    input  wire logic             is_cycle_master,
    output var  logic             irq_out_n
);
    import lism_pkg::*;

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic [31:0] rd_data;
    logic        rd_ok;
    logic        seconds_tick;
    logic        cycle_start_missing;

    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic [31:0] mask_q;
    logic        ovr_q;
    logic        pipe_arm_q;
    logic [31:0] lane_m;
    logic        wr_flags;
    logic        wr_mask;
    logic        wr_test;
    logic [31:0] set_vec;
    logic [31:0] hw_clr;
    logic [31:0] sw_clr;
    logic        summary;

    lism_axil u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    lism_cyc_watch u_cyc (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .cycle_seconds        (cycle_seconds),
        .cycle_wrap           (evt.cycle_wrap),
        .cycle_start_received (evt.cycle_start_received),
        .is_cycle_master      (is_cycle_master),
        .seconds_tick         (seconds_tick),
        .cycle_start_missing  (cycle_start_missing)
    );

    // write decode; unmapped writes answer with an error
    assign lane_m   = lism_strb_mask(wr_strb);
    assign wr_flags = wr_en && (wr_addr == LISM_FLAGS_ADDR);
    assign wr_mask  = wr_en && (wr_addr == LISM_MASK_ADDR);
    assign wr_test  = wr_en && (wr_addr == LISM_TEST_ADDR);
    assign wr_ok    = (wr_addr == LISM_FLAGS_ADDR) ||
                      (wr_addr == LISM_MASK_ADDR) ||
                      (wr_addr == LISM_TEST_ADDR);

    // summary: enabled flags only, bit 31 of the mask excluded
    assign summary = |(flags_q[30:0] & mask_q[30:0]);

    // hardware events that raise a flag
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[LISM_B_ALERT]   = evt.phys_layer_alert;
        set_vec[LISM_B_PHYREG]  = evt.phys_register_data_arrived;
        set_vec[LISM_B_BUS_RST] = evt.bus_reset_seen;
        set_vec[LISM_B_GAP]     = evt.fair_gap_seen;
        set_vec[LISM_B_TXFREE]  = evt.ack_settled;
        set_vec[LISM_B_ACKRX]   = evt.acknowledge_received;
        set_vec[LISM_B_RXGOOD]  = evt.good_packet_received;
        set_vec[LISM_B_CSRRST]  = evt.csr_reset_write_seen;
        set_vec[LISM_B_SELFID]  = evt.self_identify_done;
        set_vec[LISM_B_ASYNCQ]  = evt.async_queue_fault;
        set_vec[LISM_B_BUSY]    = evt.busy_reply_sent;
        set_vec[LISM_B_HDRCRC]  = evt.header_crc_fault;
        set_vec[LISM_B_TCODE]   = evt.transaction_code_fault;
        set_vec[LISM_B_SEC]     = seconds_tick;
        set_vec[LISM_B_CYCLE_START_SEEN]   = evt.cycle_start_seen;
        set_vec[LISM_B_CYCDONE] = evt.cycle_finished;
        set_vec[LISM_B_CYCPEND] = evt.cycle_offset_zero;
        set_vec[LISM_B_CYCMISS] = cycle_start_missing;
        set_vec[LISM_B_ARBLOST] = evt.cycle_start_arbitration_lost;
        set_vec[LISM_B_PIPE]    = evt.pipe_fault;
    end

    // hardware clears: transmitter busy, pending cycle finished
    always_comb begin
        hw_clr = 32'h0000_0000;
        hw_clr[LISM_B_TXFREE]  = evt.packet_sent;
        hw_clr[LISM_B_CYCPEND] = evt.cycle_finished;
    end

    // software write-one clears; pipe fault needs the arm bit first
    always_comb begin
        sw_clr = 32'h0000_0000;
        if (wr_flags && !ovr_q) begin
            sw_clr = wr_data & lane_m & LISM_FLAG_W1C;
            sw_clr[LISM_B_PIPE] = pipe_arm_q && wr_data[LISM_B_PIPE] &&
                                  lane_m[LISM_B_PIPE];
        end
    end

    // next flags: clears first, then sets so a same-cycle event wins
    always_comb begin
        flags_d = flags_q & ~hw_clr & ~sw_clr;
        if (wr_flags && ovr_q) begin
            flags_d = (flags_d & ~lane_m) | (wr_data & lane_m);
        end
        flags_d = (flags_d | set_vec) & LISM_FLAG_USED;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= LISM_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // enable mask, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= LISM_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= (mask_q & ~lane_m) | (wr_data & lane_m);
        end
    end

    // override and pipe arm bits, normally owned by neighbour registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {pipe_arm_q, ovr_q} <= LISM_TEST_RST;
        end else if (wr_test && wr_strb[0]) begin
            ovr_q      <= wr_data[LISM_T_OVR];
            pipe_arm_q <= wr_data[LISM_T_PIPE];
        end
    end

    // registered pin: one cycle behind the flags, glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= !(summary && mask_q[LISM_B_SUM]);
        end
    end

    // read mux; the summary bit is always live, never stored
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            LISM_FLAGS_ADDR: rd_data = {summary, flags_q[30:0]};
            LISM_MASK_ADDR:  rd_data = mask_q;
            LISM_TEST_ADDR: begin
                rd_data[LISM_T_OVR]  = ovr_q;
                rd_data[LISM_T_PIPE] = pipe_arm_q;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_RESET_ZERO : assert property (
        $past(!aresetn) |-> (flags_q == 32'h0 && mask_q == 32'h0 &&
                             irq_out_n))
        else $error("flags or mask not zero after reset");

    AST_W1C_CLEARS : assert property (
        sw_clr != 32'h0 |=>
            (flags_q & $past(sw_clr) & ~$past(set_vec)) == 32'h0)
        else $error("write-one did not clear flag");

    AST_PIPE_HOLD : assert property (
        wr_flags && !ovr_q && !pipe_arm_q && flags_q[LISM_B_PIPE]
            |=> flags_q[LISM_B_PIPE])
        else $error("pipe fault cleared without arm");

    AST_OVR_WRITE : assert property (
        wr_flags && ovr_q && set_vec == 32'h0 && hw_clr == 32'h0 &&
        wr_strb == 4'hf
            |=> flags_q == ($past(wr_data) & LISM_FLAG_USED))
        else $error("override write not stored");

    AST_MASK_WRITE : assert property (
        wr_mask && wr_strb == 4'hf |=> mask_q == $past(wr_data))
        else $error("mask write not stored");

    AST_IRQ_OFF : assert property (
        !mask_q[LISM_B_SUM] |=> irq_out_n)
        else $error("interrupt active while disabled");

    AST_IRQ_ON : assert property (
        (summary && mask_q[LISM_B_SUM]) |=> !irq_out_n)
        else $error("interrupt missing for enabled flag");

    AST_SET_WINS : assert property (
        set_vec != 32'h0 |=>
            (flags_q & $past(set_vec)) == ($past(set_vec) & LISM_FLAG_USED))
        else $error("event lost");

    AST_STICKY : assert property (
        !wr_flags && hw_clr == 32'h0 ##1 1'b1 |->
            (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without clear");

    AST_ISO_ZERO : assert property (
        !flags_q[LISM_B_ISOQ])
        else $error("iso queue fault bit set");

    AST_TX_LOW : assert property (
        evt.packet_sent && !evt.ack_settled |=> !flags_q[LISM_B_TXFREE])
        else $error("transmitter free not dropped");

    AST_PEND_END : assert property (
        evt.cycle_finished && !evt.cycle_offset_zero |=>
            !flags_q[LISM_B_CYCPEND])
        else $error("cycle pending not released");

    // each source checked from its own pulse, not through set_vec
    AST_PHYREG_SET : assert property (
        evt.phys_register_data_arrived |=> flags_q[LISM_B_PHYREG])
        else $error("flag 29 not set");

    AST_CSR_SET : assert property (
        evt.csr_reset_write_seen |=> flags_q[LISM_B_CSRRST])
        else $error("flag 24 not set");

    AST_ACK_SET : assert property (
        evt.acknowledge_received |=> flags_q[LISM_B_ACKRX])
        else $error("flag 22 not set");

    AST_BUSY_SET : assert property (
        evt.busy_reply_sent |=> flags_q[LISM_B_BUSY])
        else $error("flag 17 not set");

    AST_HDR_SET : assert property (
        evt.header_crc_fault |=> flags_q[LISM_B_HDRCRC])
        else $error("flag 16 not set");

    AST_TCODE_SET : assert property (
        evt.transaction_code_fault |=> flags_q[LISM_B_TCODE])
        else $error("flag 15 not set");

    AST_SEC_SET : assert property (
        seconds_tick |=> flags_q[LISM_B_SEC])
        else $error("flag 11 not set");

    AST_MISS_SET : assert property (
        cycle_start_missing |=> flags_q[LISM_B_CYCMISS])
        else $error("flag 7 not set");

    AST_SUM_READ : assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == LISM_FLAGS_ADDR
            |=> s_axi_rdata[LISM_B_SUM] == $past(summary))
        else $error("summary bit not read back");

    AST_USED_ONLY : assert property (
        (flags_q & ~LISM_FLAG_USED) == 32'h0)
        else $error("unused flag bit set");

    COV_MISS : cover property (cycle_start_missing && !is_cycle_master);
    COV_IRQ : cover property (!irq_out_n ##1 irq_out_n);
    COV_W1C : cover property (sw_clr != 32'h0 ##1 !irq_out_n);
    COV_OVR : cover property (wr_flags && ovr_q);
    COV_PIPE : cover property (sw_clr[LISM_B_PIPE]);
endmodule
`default_nettype wire

// *** tb/lism_host.sv ***
/* lism_host: AXI4-Lite master in the host cpu's place.
 * Assumes the bench runs one transfer at a time. */
`timescale 1ns/1ps
`default_nettype none
module lism_host (
    input  wire logic        aclk,
    output var  logic [7:0]  awaddr,
    output var  logic        awvalid,
    input  wire logic        awready,
    output var  logic [31:0] wdata,
    output var  logic [3:0]  wstrb,
    output var  logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output var  logic        bready,
    output var  logic [7:0]  araddr,
    output var  logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var  logic        rready
);
    // bus idle from time zero, full words only
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, wstrb} = 14'h000f;
    end
    // one write or read; each channel drops at its own handshake and
    // the answer is taken as sampled at the valid edge, not after it
    task automatic io(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic [1:0] r);
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready} <= {3{we}};
        {arvalid, rready} <= {2{!we}};
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if ((bvalid && bready) || (rvalid && rready)) break;
        end
        {bready, rready} <= 2'h0;
        q = rdata;
        r = we ? bresp : rresp;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/* tb_top: self-checking bench for lism_top through the host model.
 * Assumes event inputs are single-cycle pulses on aclk. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lism_pkg::*;
    localparam logic [7:0] FLG = LISM_FLAGS_ADDR, MSK = LISM_MASK_ADDR;
    logic        aclk = 1'b0, aresetn = 1'b0, master = 1'b0;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, irq_n;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [6:0]  secs = 7'h05;
    lism_evt_s   evt = '0;
    int          error_cnt = 0, n_checks = 0;
    // event index in evt beside the flag bit it raises
    int rows [17][2] = '{'{20, 30}, '{19, 29}, '{18, 28}, '{17, 27},
        '{15, 26}, '{14, 25}, '{13, 24}, '{12, 23}, '{11, 22}, '{10, 19},
        '{9, 17}, '{8, 16}, '{7, 15}, '{6, 10}, '{4, 9}, '{1, 6}, '{3, 8}};
    // 40 MHz
    always #12.5 aclk = ~aclk;
    lism_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt),
        .cycle_seconds(secs), .is_cycle_master(master), .irq_out_n(irq_n));
    lism_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // compare helpers; case inequality so x never matches
    task automatic chk(input string n, input logic [31:0] e, s);
        n_checks++;
        error_cnt += int'(s !== e);
        if (s !== e) $display("[FAIL] %s expected %h seen %h", n, e, s);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        i_host.io(1'b0, a, 32'h0, rd, rs);
        chk($sformatf("reg %h", a), e, rd);
        chk("rresp", 32'(LISM_RESP_OKAY), 32'(rs));
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        i_host.io(1'b1, a, d, rd, rs);
        chk("bresp", 32'(LISM_RESP_OKAY), 32'(rs));
    endtask
    task automatic pulse(input int i);
        @(posedge aclk);
        evt <= lism_evt_s'(21'h1 << i);
        @(posedge aclk);
        evt <= '0;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // tests take well under a thousand cycles
    initial begin
        repeat (4000) @(posedge aclk);
        error_cnt++;
        give_verdict();
    end
    // reset values, then one row for each of 17 event sources with the mask off
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rc(FLG, 32'h0);
        rc(MSK, 32'h0);
        chk("irq_out_n", 32'h1, 32'(irq_n));
        i_host.io(1'b0, 8'h04, 32'h0, rd, rs);
        chk("rresp", 32'(LISM_RESP_SLVERR), 32'(rs));
        for (int i = 0; i < 17; i++) begin
            pulse(rows[i][0]);
            rc(FLG, 32'h1 << rows[i][1]);
            w(FLG, 32'h1 << rows[i][1]);
        end
        // a flag left over by the last row would show up here
        w(MSK, 32'hffff_ffff);
        rc(MSK, 32'hffff_ffff);
        pulse(18);
        rc(FLG, 32'h9000_0000);
        chk("irq_out_n", 32'h0, 32'(irq_n));
        w(MSK, 32'h7fff_ffff);
        rc(FLG, 32'h9000_0000);
        chk("irq_out_n", 32'h1, 32'(irq_n));
        w(MSK, 32'h0);
        // override on, then write-one clears all but the pipe fault
        w(LISM_TEST_ADDR, 32'h1);
        w(FLG, 32'hffff_ffff);
        rc(FLG, LISM_FLAG_USED);
        w(LISM_TEST_ADDR, 32'h0);
        w(FLG, 32'hffff_ffff);
        rc(FLG, 32'h8);
        w(LISM_TEST_ADDR, 32'h2);
        w(FLG, 32'h8);
        rc(FLG, 32'h0);
        pulse(0);
        rc(FLG, 32'h8);
        w(FLG, 32'h8);
        rc(FLG, 32'h0);
        // sets and clears of the transmitter and cycle flags, one wrap is not enough
        pulse(15);
        pulse(16);
        pulse(3);
        rc(FLG, 32'h100);
        pulse(4);
        pulse(2);
        rc(FLG, 32'h200);
        pulse(2);
        rc(FLG, 32'h280);
        secs <= 7'h06;
        @(posedge aclk);
        rc(FLG, 32'ha80);
        w(FLG, 32'ha80);
        pulse(2);
        pulse(5);
        pulse(2);
        master <= 1'b1;
        pulse(2);
        pulse(2);
        rc(FLG, 32'h0);
        // reset in mid-run with a flag and the whole mask set
        w(MSK, 32'hffff_ffff);
        pulse(20);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk("irq_out_n", 32'h1, 32'(irq_n));
        rc(FLG, 32'h0);
        rc(MSK, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
